// >>> logic/mwvd_pkg.sv
/*
 * Constants shared by the receive-side wake-up and second-tag detection block:
 * register indices, field positions, reset values, frame limits and filter layout.
 * Assumes a 32-bit Avalon-MM register bus whose byte address is four times the index.
 */
package mwvd_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam int unsigned ADDR_W = 8;
   localparam logic [5:0] IDX_SECOND_TAG = 6'h0A;
   localparam logic [5:0] IDX_FILTER_PORT = 6'h0B;
   localparam logic [5:0] IDX_WAKE_CTRL = 6'h0C;
   localparam logic [31:0] RST_SECOND_TAG = 32'h00000000;
   localparam logic [31:0] RST_WAKE_CTRL = 32'h00000000;
   localparam logic [31:0] RST_FILTER_WORD = 32'h00000000;
   localparam logic [31:0] READ_ZERO = 32'h00000000;

   // ****************************************************************
   // Wake control and status fields
   // ****************************************************************
   localparam int unsigned BIT_GLOBAL_UNICAST = 9;
   localparam int unsigned BIT_FRAME_SEEN = 6;
   localparam int unsigned BIT_PATTERN_SEEN = 5;
   localparam int unsigned BIT_FRAME_ENABLE = 2;
   localparam int unsigned BIT_PATTERN_ENABLE = 1;
   localparam int unsigned TAG_W = 16;

   // ****************************************************************
   // Frame limits
   // ****************************************************************
   localparam int unsigned LEN_W = 11;
   localparam logic [10:0] MAX_LEN_PLAIN = 11'd1518;
   localparam logic [10:0] MAX_LEN_TAGGED = 11'd1522;
   localparam logic [10:0] LEN_SAT = 11'h7FF;
   localparam logic [10:0] TAG_HI_POS = 11'd12;
   localparam logic [10:0] TAG_LO_POS = 11'd13;
   localparam logic [10:0] DEST_FIRST_POS = 11'h000;

   // ****************************************************************
   // Wake filter layout: four masks, then enables, offsets, two CRC words
   // ****************************************************************
   localparam int unsigned FILTER_WORDS = 8;
   localparam int unsigned FILTER_PTR_W = 3;
   localparam int unsigned NUM_FILTERS = 4;
   localparam int unsigned ENTRY_ENABLES = 4;
   localparam int unsigned ENTRY_OFFSETS = 5;
   localparam int unsigned ENTRY_CRC_LO = 6;
   localparam int unsigned ENTRY_CRC_HI = 7;
   localparam int unsigned MASK_SPAN = 32;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'h8005;

   // ****************************************************************
   // Pattern packet: six sync bytes then sixteen station address copies
   // ****************************************************************
   localparam logic [7:0] SYNC_BYTE = 8'hFF;
   localparam logic [2:0] SYNC_COUNT = 3'd6;
   localparam logic [2:0] ADDR_BYTES = 3'd6;
   localparam logic [6:0] PATTERN_BYTES = 7'd96;

   typedef enum {BUS_IDLE, BUS_ANSWER} mwvd_bus_state_t;

endpackage : mwvd_pkg

// >>> logic/mwvd_top.sv
/*
 * Receive-side block: second-tag frame detection with length check, the
 * write-only wake filter loading port and the wake control and status flags.
 * Assumes received bytes arrive in the same clock domain, one per rx_valid,
 * with rx_last on the final byte and rx_good telling whether the frame check passed.
 */
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps

module mwvd_top
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [mwvd_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_last,
   input wire logic rx_good,
   input wire logic [47:0] station_addr,
   input wire logic power_save,
   output logic frame_done,
   output logic frame_tagged,
   output logic frame_len_ok,
   output logic wake_out
);
   import mwvd_pkg::*;

   mwvd_bus_state_t bus_state_reg;
   logic [31:0] readdata_reg;
   logic waitreq_reg;
   logic [TAG_W-1:0] second_tag_identifier_reg;
   logic [31:0] wake_filter_word_reg [FILTER_WORDS];
   logic [FILTER_PTR_W-1:0] filter_ptr_reg;
   logic global_unicast_wake_enable_reg;
   logic wake_frame_enable_reg;
   logic wake_pattern_enable_reg;
   logic wake_frame_seen_reg;
   logic wake_pattern_packet_seen_reg;
   logic [LEN_W-1:0] byte_cnt_reg;
   logic tag_hi_hit_reg;
   logic tagged_reg;
   logic unicast_reg;
   logic frame_done_reg;
   logic frame_tagged_reg;
   logic frame_len_ok_reg;
   logic wake_out_reg;
   logic [2:0] sync_run_reg;
   logic [2:0] addr_sel_reg;
   logic [6:0] pattern_idx_reg;
   logic pattern_hit_reg;
   logic [15:0] crc_reg [NUM_FILTERS];
   logic [NUM_FILTERS-1:0] filter_hit;
   logic [5:0] reg_index;
   logic bus_req;
   logic bus_take;
   logic [31:0] wmask;
   logic [LEN_W-1:0] frame_len;
   logic [7:0] addr_byte;
   logic frame_end;
   logic pattern_now;

   // One CRC-16 step over a received byte, least significant bit first.
   function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] data);
      logic [15:0] c;
      c = crc;
      for (int b = 0; b < 8; b++)
      begin
         if (c[15] ^ data[b])
            c = {c[14:0], 1'b0} ^ CRC_POLY;
         else
            c = {c[14:0], 1'b0};
      end
      return c;
   endfunction : crc_step

   // ****************************************************************
   // Avalon-MM slave
   // ****************************************************************

   // A request is taken at the edge where waitrequest was sampled low.
   assign reg_index = avs_address[ADDR_W-1:2];
   assign bus_req = avs_read | avs_write;
   assign bus_take = bus_req & ~waitreq_reg;
   assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   // Waitrequest drops for exactly one cycle per request, so a held request is
   // answered once and read data is ready in the same cycle.
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         bus_state_reg <= BUS_IDLE;
         waitreq_reg <= 1'b1;
      end
      else
      begin
         unique case (bus_state_reg)
            BUS_IDLE:
            begin
               if (bus_req)
               begin
                  bus_state_reg <= BUS_ANSWER;
                  waitreq_reg <= 1'b0;
               end
            end
            BUS_ANSWER:
            begin
               bus_state_reg <= BUS_IDLE;
               waitreq_reg <= 1'b1;
            end
         endcase
      end
   end

   // Read data is captured as waitrequest drops; unmapped indices read zero.
   always_ff @(posedge clk)
   begin
      if (!rstn)
         readdata_reg <= READ_ZERO;
      else if (bus_state_reg == BUS_IDLE && avs_read)
      begin
         readdata_reg <= READ_ZERO;
         if (reg_index == IDX_SECOND_TAG)
            readdata_reg[TAG_W-1:0] <= second_tag_identifier_reg;
         else if (reg_index == IDX_WAKE_CTRL)
         begin
            readdata_reg[BIT_GLOBAL_UNICAST] <= global_unicast_wake_enable_reg;
            readdata_reg[BIT_FRAME_SEEN] <= wake_frame_seen_reg;
            readdata_reg[BIT_PATTERN_SEEN] <= wake_pattern_packet_seen_reg;
            readdata_reg[BIT_FRAME_ENABLE] <= wake_frame_enable_reg;
            readdata_reg[BIT_PATTERN_ENABLE] <= wake_pattern_enable_reg;
         end
         // filter port reads zero
         // The filter loading port falls through to zero: contents never leave.
      end
   end

   assign avs_readdata = readdata_reg;
   assign avs_waitrequest = waitreq_reg;

   // Tag identifier register; only the low half is stored, the rest reads zero.
   always_ff @(posedge clk)
   begin
      if (!rstn)
         second_tag_identifier_reg <= RST_SECOND_TAG[TAG_W-1:0];
      else if (bus_take && avs_write && reg_index == IDX_SECOND_TAG)
         second_tag_identifier_reg <= (avs_writedata[TAG_W-1:0] & wmask[TAG_W-1:0]) |
                                      (second_tag_identifier_reg & ~wmask[TAG_W-1:0]);
   end

   // Wake control bits; the seen flags clear when software writes one to them.
   // sticky status, set beats clear
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         global_unicast_wake_enable_reg <= RST_WAKE_CTRL[BIT_GLOBAL_UNICAST];
         wake_frame_enable_reg <= RST_WAKE_CTRL[BIT_FRAME_ENABLE];
         wake_pattern_enable_reg <= RST_WAKE_CTRL[BIT_PATTERN_ENABLE];
         wake_frame_seen_reg <= RST_WAKE_CTRL[BIT_FRAME_SEEN];
         wake_pattern_packet_seen_reg <= RST_WAKE_CTRL[BIT_PATTERN_SEEN];
      end
      else
      begin
         if (bus_take && avs_write && reg_index == IDX_WAKE_CTRL)
         begin
            if (avs_byteenable[1])
               global_unicast_wake_enable_reg <= avs_writedata[BIT_GLOBAL_UNICAST];
            if (avs_byteenable[0])
            begin
               wake_frame_enable_reg <= avs_writedata[BIT_FRAME_ENABLE];
               wake_pattern_enable_reg <= avs_writedata[BIT_PATTERN_ENABLE];
               if (avs_writedata[BIT_FRAME_SEEN])
                  wake_frame_seen_reg <= 1'b0;
               if (avs_writedata[BIT_PATTERN_SEEN])
                  wake_pattern_packet_seen_reg <= 1'b0;
            end
         end
         if (frame_end && rx_good && wake_frame_enable_reg && |filter_hit)
            wake_frame_seen_reg <= 1'b1;
         if (frame_end && rx_good && wake_pattern_enable_reg && pattern_now)
            wake_pattern_packet_seen_reg <= 1'b1;
      end
   end

   // ****************************************************************
   // Wake filter loading port
   // ****************************************************************

   // Each write fills the entry under the pointer; byte enables merge partial words.
   // first write after reset to entry zero
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         filter_ptr_reg <= '0;
         for (int i = 0; i < FILTER_WORDS; i++)
            wake_filter_word_reg[i] <= RST_FILTER_WORD;
      end
      else if (bus_take && avs_write && reg_index == IDX_FILTER_PORT)
      begin
         wake_filter_word_reg[filter_ptr_reg] <= (avs_writedata & wmask) |
                                                 (wake_filter_word_reg[filter_ptr_reg] & ~wmask);
         filter_ptr_reg <= filter_ptr_reg + 3'd1;
      end
   end

   // ****************************************************************
   // Receive frame tracking
   // ****************************************************************

   assign frame_end = rx_valid & rx_last;
   // A saturated count must not wrap back round to a short length and pass.
   assign frame_len = (byte_cnt_reg == LEN_SAT) ? LEN_SAT : byte_cnt_reg + 11'd1;

   // Byte position within the frame, saturating so oversized frames stay long.
   always_ff @(posedge clk)
   begin
      if (!rstn)
         byte_cnt_reg <= '0;
      else if (frame_end)
         byte_cnt_reg <= '0;
      else if (rx_valid && byte_cnt_reg != LEN_SAT)
         byte_cnt_reg <= byte_cnt_reg + 11'd1;
   end

   // Tag match over the two type bytes, and the unicast test on the first byte.
   // bytes thirteen and fourteen
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         tag_hi_hit_reg <= 1'b0;
         tagged_reg <= 1'b0;
         unicast_reg <= 1'b0;
      end
      else if (frame_end)
      begin
         tag_hi_hit_reg <= 1'b0;
         tagged_reg <= 1'b0;
         unicast_reg <= 1'b0;
      end
      else if (rx_valid)
      begin
         if (byte_cnt_reg == DEST_FIRST_POS)
            unicast_reg <= ~rx_data[0];
         if (byte_cnt_reg == TAG_HI_POS)
            tag_hi_hit_reg <= (rx_data == second_tag_identifier_reg[15:8]);
         if (byte_cnt_reg == TAG_LO_POS)
            tagged_reg <= tag_hi_hit_reg && (rx_data == second_tag_identifier_reg[7:0]);
      end
   end

   // Per-frame results registered at the last byte; frame_done pulses for one cycle, tag and length flags hold until the next frame.
   // longer limit for tagged frames
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         frame_done_reg <= 1'b0;
         frame_tagged_reg <= 1'b0;
         frame_len_ok_reg <= 1'b0;
      end
      else
      begin
         frame_done_reg <= frame_end;
         if (frame_end)
         begin
            frame_tagged_reg <= tagged_reg;
            frame_len_ok_reg <= frame_len <= (tagged_reg ? MAX_LEN_TAGGED : MAX_LEN_PLAIN);
         end
      end
   end

   // ****************************************************************
   // Wake frame filters
   // ****************************************************************

   // Each filter hashes the masked bytes of a 32-byte window starting at its offset.
   // filter-based wake frame detection
   for (genvar f = 0; f < NUM_FILTERS; f++)
   begin : g_filter
      logic [7:0] offset;
      logic [LEN_W-1:0] rel;
      logic in_window;
      logic [15:0] crc_want;
      logic [15:0] crc_now;
      assign offset = wake_filter_word_reg[ENTRY_OFFSETS][f*8 +: 8];
      assign rel = byte_cnt_reg - {3'b000, offset};
      assign in_window = (byte_cnt_reg >= {3'b000, offset}) && (rel < LEN_W'(MASK_SPAN));
      assign crc_want = (f < 2) ? wake_filter_word_reg[ENTRY_CRC_LO][(f%2)*16 +: 16] :
                                  wake_filter_word_reg[ENTRY_CRC_HI][(f%2)*16 +: 16];
      assign crc_now = (in_window && wake_filter_word_reg[f][rel[4:0]]) ?
                       crc_step(crc_reg[f], rx_data) : crc_reg[f];
      assign filter_hit[f] = wake_filter_word_reg[ENTRY_ENABLES][f*8] && (crc_now == crc_want);

      always_ff @(posedge clk)
      begin
         if (!rstn || frame_end)
            crc_reg[f] <= CRC_INIT;
         else if (rx_valid)
            crc_reg[f] <= crc_now;
      end
   end

   // ****************************************************************
   // Pattern packet recognition
   // ****************************************************************

   assign addr_byte = station_addr[8*(5 - addr_sel_reg) +: 8];
   assign pattern_now = pattern_hit_reg ||
                        (sync_run_reg == SYNC_COUNT && rx_data == addr_byte &&
                         pattern_idx_reg == PATTERN_BYTES - 7'd1);

   // Count sync bytes, then walk sixteen station address copies byte by byte.
   // pattern packet recognition
   always_ff @(posedge clk)
   begin
      if (!rstn || frame_end)
      begin
         sync_run_reg <= '0;
         addr_sel_reg <= '0;
         pattern_idx_reg <= '0;
         pattern_hit_reg <= 1'b0;
      end
      else if (rx_valid && !pattern_hit_reg)
      begin
         if (sync_run_reg == SYNC_COUNT && rx_data == addr_byte)
         begin
            pattern_idx_reg <= pattern_idx_reg + 7'd1;
            addr_sel_reg <= (addr_sel_reg == ADDR_BYTES - 3'd1) ? 3'd0 : addr_sel_reg + 3'd1;
            pattern_hit_reg <= pattern_now;
         end
         else
         begin
            // A sync byte in the wrong place restarts the address walk but keeps the run.
            pattern_idx_reg <= '0;
            addr_sel_reg <= '0;
            if (rx_data == SYNC_BYTE)
               sync_run_reg <= (sync_run_reg == SYNC_COUNT) ? SYNC_COUNT : sync_run_reg + 3'd1;
            else
               sync_run_reg <= '0;
         end
      end
   end

   // Leaving power saving is signalled by a one-cycle pulse after a good frame.
   // global unicast, wake frame and pattern packet wake
   always_ff @(posedge clk)
   begin
      if (!rstn)
         wake_out_reg <= 1'b0;
      else
         wake_out_reg <= frame_end && rx_good && power_save &&
                         ((global_unicast_wake_enable_reg && unicast_reg) ||
                          (wake_frame_enable_reg && |filter_hit) ||
                          (wake_pattern_enable_reg && pattern_now));
   end

   assign frame_done = frame_done_reg;
   assign frame_tagged = frame_tagged_reg;
   assign frame_len_ok = frame_len_ok_reg;
   assign wake_out = wake_out_reg;

   // ****************************************************************
   // Assertions
   // ****************************************************************

   a_bus_answer: assert property (@(posedge clk) disable iff (!rstn)
      (bus_state_reg == BUS_IDLE && bus_req) |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("Waitrequest did not pulse low for one cycle.");

   a_filter_readzero: assert property (@(posedge clk) disable iff (!rstn)
      (bus_state_reg == BUS_IDLE && avs_read && reg_index == IDX_FILTER_PORT)
      |=> avs_readdata == READ_ZERO)
      else $error("Filter port read returned data.");

   a_ptr_advance: assert property (@(posedge clk) disable iff (!rstn)
      (bus_take && avs_write && reg_index == IDX_FILTER_PORT)
      |=> filter_ptr_reg == $past(filter_ptr_reg) + 3'd1)
      else $error("Filter pointer did not advance on a write.");

   a_ptr_wrap: assert property (@(posedge clk) disable iff (!rstn)
      (bus_take && avs_write && reg_index == IDX_FILTER_PORT && filter_ptr_reg == 3'd7)
      |=> filter_ptr_reg == 3'd0)
      else $error("Filter pointer did not wrap to entry zero.");

   a_tag_detect: assert property (@(posedge clk) disable iff (!rstn)
      (frame_end && tagged_reg) |=> frame_tagged && frame_done)
      else $error("Tagged frame not reported.");

   a_len_limit: assert property (@(posedge clk) disable iff (!rstn)
      (frame_end && !tagged_reg && frame_len > MAX_LEN_PLAIN) |=> !frame_len_ok)
      else $error("Oversized untagged frame accepted.");

   a_unicast_wake: assert property (@(posedge clk) disable iff (!rstn)
      (frame_end && rx_good && power_save && global_unicast_wake_enable_reg && unicast_reg)
      |=> wake_out ##1 !wake_out)
      else $error("Unicast wake pulse missing.");

   a_frame_seen: assert property (@(posedge clk) disable iff (!rstn)
      (frame_end && rx_good && wake_frame_enable_reg && |filter_hit) |=> wake_frame_seen_reg)
      else $error("Wake frame flag not set.");

   a_pattern_seen: assert property (@(posedge clk) disable iff (!rstn)
      (frame_end && rx_good && wake_pattern_enable_reg && pattern_now)
      |=> wake_pattern_packet_seen_reg)
      else $error("Pattern packet flag not set.");

   a_seen_sticky: assert property (@(posedge clk) disable iff (!rstn)
      (wake_frame_seen_reg && !(bus_take && avs_write && reg_index == IDX_WAKE_CTRL))
      |=> wake_frame_seen_reg)
      else $error("Wake frame flag dropped without a clear.");

endmodule : mwvd_top

// >>> verif/mwvd_net_model.sv
/*
 * Network side model: feeds whole frames into the block, at most one byte per cycle.
 * Assumes it runs on the block clock and that the bench hands it complete frames.
 */
`timescale 1ns/1ps
module mwvd_net_model
(
   input wire logic clk,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_last,
   output logic rx_good
);
   logic busy = 1'b0;

   // ****************************************************************
   // Idle line
   // ****************************************************************
   // Lines start quiet at time zero.
   initial
   begin
      rx_valid = 1'b0;
      rx_data = 8'hA5;
      rx_last = 1'b0;
      rx_good = 1'b0;
   end

   // Between frames data and status churn, so a stale byte is never trusted.
   always @(posedge clk)
   begin
      if (!busy)
      begin
         rx_data <= ~rx_data;
         rx_good <= ~rx_good;
      end
   end

   // Sends one frame; idle gaps between bytes model a slow link.
   task automatic send(input logic [7:0] f[$], input int gap, input logic good);
      busy = 1'b1;
      foreach (f[i])
      begin
         @(posedge clk);
         rx_valid <= 1'b1;
         rx_data <= f[i];
         rx_last <= (i == f.size() - 1);
         rx_good <= good;
         if (i < f.size() - 1)
            repeat (gap)
            begin
               @(posedge clk);
               rx_valid <= 1'b0;
               rx_data <= ~f[i];
            end
      end
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_last <= 1'b0;
      busy = 1'b0;
   endtask : send
endmodule : mwvd_net_model

// >>> verif/mwvd_top_tb_top.sv
/*
 * Self-checking bench for the wake-up and second-tag block.
 * Assumes the block answers on Avalon-MM and the network model supplies frames.
 */
`timescale 1ns/1ps
module mwvd_top_tb_top;
   import mwvd_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [ADDR_W-1:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic rx_valid, rx_last, rx_good, frame_done, frame_tagged, frame_len_ok, wake_out;
   logic [7:0] rx_data;
   logic power_save = 1'b0;
   logic [47:0] station_addr = 48'h021122334455;
   logic [7:0] fr[$];
   logic [31:0] q;
   int n_errors = 0;
   int total_checks = 0;

   // Clock of 50 ns period.
   always #25 clk = ~clk;

   mwvd_top dut (.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_last(rx_last), .rx_good(rx_good), .station_addr(station_addr),
      .power_save(power_save), .frame_done(frame_done), .frame_tagged(frame_tagged),
      .frame_len_ok(frame_len_ok), .wake_out(wake_out));
   mwvd_net_model net (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_last(rx_last), .rx_good(rx_good));

   // ****************************************************************
   // Helpers
   // ****************************************************************
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e)
      begin
         n_errors++;
         $display("BAD t=%0t seen %h want %h", $time, s, e);
      end
   endtask : chk

   // One bus cycle; the request is held until waitrequest is sampled low.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50)
      begin
         n_errors++;
         wrap_up();
      end
   endtask : bus

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h00000000);
      chk(q, e);
   endtask : rd

   task automatic mk(input int len);
      fr.delete();
      for (int i = 0; i < len; i++)
         fr.push_back(i[7:0] ^ 8'h5A);
   endtask : mk

   // Sends the frame, then looks at the outputs once the end-of-frame edge has landed.
   task automatic tx(input int gap, input logic good, input logic [3:0] e);
      net.send(fr, gap, good);
      #1;
      chk(32'({frame_done, frame_tagged, frame_len_ok, wake_out}), 32'(e));
   endtask : tx

   // Expected filter check value of one selected byte, worked out independently.
   function automatic logic [15:0] crc(input logic [7:0] b);
      logic [15:0] c;
      c = CRC_INIT;
      for (int i = 0; i < 8; i++)
         c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? CRC_POLY : 16'h0000);
      return c;
   endfunction : crc

   // Loads filter 0 on byte 0; a set bad flag spoils the check value.
   task automatic ld(input logic bad);
      logic [31:0] w;
      for (int i = 0; i < FILTER_WORDS; i++)
      begin
         w = (i == 0 || i == 4) ? 32'h00000001 : 32'h00000000;
         if (i == 6)
            w = {16'h0000, crc(8'h5A) ^ {15'h0000, bad}};
         bus(1'b1, 8'h2C, w);
      end
   endtask : ld

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_regs;
      rd(8'h28, RST_SECOND_TAG);
      rd(8'h30, RST_WAKE_CTRL);
      rd(8'h2C, READ_ZERO);
      bus(1'b1, 8'h3C, 32'hFFFFFFFF);
      rd(8'h3C, READ_ZERO);
      $display("t_regs done");
   endtask : t_regs

   task automatic t_tag;
      bus(1'b1, 8'h28, 32'hFFFF8100);
      rd(8'h28, 32'h00008100);
      mk(1522);
      fr[12] = 8'h81;
      fr[13] = 8'h00;
      tx(0, 1'b1, 4'hE);
      fr.push_back(8'h00);
      tx(0, 1'b1, 4'hC);
      mk(1518);
      tx(0, 1'b1, 4'hA);
      mk(1519);
      tx(0, 1'b1, 4'h8);
      mk(2100);
      tx(0, 1'b1, 4'h8);
      mk(64);
      fr[12] = 8'h81;
      fr[13] = 8'h01;
      tx(0, 1'b1, 4'hA);
      fr[13] = 8'h00;
      tx(2, 1'b1, 4'hE);
      $display("t_tag done");
   endtask : t_tag

   task automatic t_filter;
      // Leave the filter pointer part way along, then reset: loading must restart at entry zero.
      bus(1'b1, 8'h2C, 32'h00000000);
      bus(1'b1, 8'h2C, 32'h00000000);
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      rd(8'h28, RST_SECOND_TAG);
      @(posedge clk);
      power_save <= 1'b1;
      bus(1'b1, 8'h30, 32'h00000004);
      mk(64);
      ld(1'b1);
      tx(0, 1'b1, 4'hA);
      ld(1'b0);
      tx(0, 1'b0, 4'hA);
      rd(8'h30, 32'h00000004);
      tx(0, 1'b1, 4'hB);
      rd(8'h30, 32'h00000044);
      fr[0] = 8'h01;
      tx(0, 1'b1, 4'hA);
      rd(8'h30, 32'h00000044);
      bus(1'b1, 8'h30, 32'h00000040);
      rd(8'h30, 32'h00000000);
      fr[0] = 8'h5A;
      tx(0, 1'b1, 4'hA);
      rd(8'h2C, READ_ZERO);
      $display("t_filter done");
   endtask : t_filter

   task automatic t_pattern;
      bus(1'b1, 8'h30, 32'h00000002);
      mk(4);
      repeat (6) fr.push_back(SYNC_BYTE);
      repeat (16)
         for (int k = 5; k >= 0; k--)
            fr.push_back(station_addr[8*k +: 8]);
      repeat (4) fr.push_back(8'h33);
      tx(0, 1'b1, 4'hB);
      rd(8'h30, 32'h00000022);
      bus(1'b1, 8'h30, 32'h00000020);
      rd(8'h30, 32'h00000000);
      tx(0, 1'b1, 4'hA);
      rd(8'h30, 32'h00000000);
      $display("t_pattern done");
   endtask : t_pattern

   task automatic t_unicast;
      bus(1'b1, 8'h30, 32'h00000200);
      mk(60);
      tx(0, 1'b1, 4'hB);
      fr[0] = 8'h01;
      tx(0, 1'b1, 4'hA);
      @(posedge clk);
      power_save <= 1'b0;
      fr[0] = 8'h5A;
      tx(0, 1'b1, 4'hA);
      rd(8'h30, 32'h00000200);
      $display("t_unicast done");
   endtask : t_unicast

   // Main sequence: reset for six cycles, then each scenario in turn.
   initial
   begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      t_regs();
      t_tag();
      t_filter();
      t_pattern();
      t_unicast();
      wrap_up();
   end
endmodule : mwvd_top_tb_top
